/* src/tlp_irq_unit.sv */
// Purpose: interrupt control with two priority levels and a compatibility mode
// Assumes: core clock pclk, APB register access, one core redirect per take pulse
// Notes: external pins pass two flops before use
//
// Overview of operation
// - priority mode: high requests vector to 0008h, low requests to 0018h
// - an enabled high request preempts a running low routine
// - each source has flag, enable and priority; clearing enable disables it
// - priority scheme works only while priority levels enable is set
// - priority mode: control bit 7 globally enables high priority sources
// - priority mode: control bit 6 globally enables low priority sources
// - flag, enable and matching global enable set cause immediate vectoring
// - priority levels enable resets clear; then priority bits have no effect
// - compatibility mode: control bit 6 gates all peripheral sources
// - compatibility mode: bit 7 gates all sources; vector always 0008h
// - taking an interrupt clears the governing global enable
// - no low priority take while a high routine runs
// - taking pushes return address and loads vector into program counter
// - return from interrupt sets the applicable global enable again
// - pin events reach the vector in three to four cycles
// - flags set on events regardless of any enable
// - control register: two globals, three enables, three flags; resets to zero
// - priority mode: bit 7 clear disables all, low priority ones included
// - priority mode: bit 6 enables or disables low priority peripheral sources
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module tlp_irq_unit
  import tlp_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // event sources
  input wire logic ext_pin0,
  input wire logic [PORT_WIDTH-1:0] port_change_pins,
  input wire tlp_event_type events,
  // core side
  input wire logic return_from_irq_instr,
  output tlp_core_type core_req,
  output logic [1:0] service_level
);

  // ***********************************
  // state
  // ***********************************
  logic [7:0] irq_control_main;
  logic priority_levels_enable;
  logic [PERIPH_COUNT-1:0] periph_flag;
  logic [PERIPH_COUNT-1:0] periph_enable;
  logic [PERIPH_COUNT-1:0] periph_priority;
  logic [7:0] core_priority;
  tlp_service_type service;
  logic [1:0] ext0_sync;
  logic [2*PORT_WIDTH-1:0] port_sync;
  logic ext0_last;
  logic [PORT_WIDTH-1:0] port_last;

  function automatic logic [7:0] merge_byte(input logic [7:0] old_val,
                                            input logic [7:0] new_val,
                                            input logic lane);
    merge_byte = lane ? new_val : old_val;
  endfunction

  // ***********************************
  // bus decode
  // ***********************************
  wire logic setup_phase = psel & ~penable;
  wire logic wr_access = psel & penable & pwrite & pstrb[0];
  wire logic hit_ctl = (paddr == ADDR_IRQ_CONTROL_MAIN);
  wire logic hit_rst = (paddr == ADDR_RESET_CONTROL);
  wire logic hit_pflag = (paddr == ADDR_PERIPH_FLAG);
  wire logic hit_pen = (paddr == ADDR_PERIPH_ENABLE);
  wire logic hit_ppri = (paddr == ADDR_PERIPH_PRIORITY);
  wire logic hit_cpri = (paddr == ADDR_CORE_PRIORITY);
  wire logic hit_stat = (paddr == ADDR_SERVICE_STATUS);
  wire logic mapped = hit_ctl | hit_rst | hit_pflag | hit_pen | hit_ppri | hit_cpri | hit_stat;
  wire logic [7:0] wbyte = pwdata[7:0];
  wire logic wr_ctl = wr_access & hit_ctl & clk_en;
  wire logic wr_rst = wr_access & hit_rst & clk_en;
  wire logic wr_pflag = wr_access & hit_pflag & clk_en;
  wire logic wr_pen = wr_access & hit_pen & clk_en;
  wire logic wr_ppri = wr_access & hit_ppri & clk_en;
  wire logic wr_cpri = wr_access & hit_cpri & clk_en;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  wire logic [1:0] status_bits = {service == TLP_LOW_SERVICE || service == TLP_HIGH_OVER_LOW,
                                  service == TLP_HIGH_SERVICE || service == TLP_HIGH_OVER_LOW};
  wire logic [7:0] read_byte =
    hit_ctl ? irq_control_main :
    hit_rst ? {priority_levels_enable, 7'h00} :
    hit_pflag ? periph_flag :
    hit_pen ? periph_enable :
    hit_ppri ? periph_priority :
    hit_cpri ? core_priority :
    hit_stat ? {6'h00, status_bits} : 8'h00;

  // ***********************************
  // pin synchronisers and edge detect
  // ***********************************
  wire logic ext0_pin_in = ext_pin0;
  wire logic ext0_now = ext0_sync[1];
  wire logic [PORT_WIDTH-1:0] port_now = port_sync[2*PORT_WIDTH-1:PORT_WIDTH];
  wire logic ext0_rise_sel = core_priority[CPRI_EXT0_EDGE];
  wire logic ext0_event = ext0_rise_sel ? (ext0_now & ~ext0_last)
                                        : (~ext0_now & ext0_last);
  wire logic port_event = |(port_now ^ port_last);

  // ***********************************
  // source gating
  // ***********************************
  wire logic [2:0] core_flags = {irq_control_main[CTL_TIMER0_FLAG],
                                 irq_control_main[CTL_EXT0_FLAG],
                                 irq_control_main[CTL_PORT_FLAG]};
  wire logic [2:0] core_enables = {irq_control_main[CTL_TIMER0_EN],
                                   irq_control_main[CTL_EXT0_EN],
                                   irq_control_main[CTL_PORT_EN]};
  wire logic [2:0] core_prio = core_priority[2:0];
  wire logic [2:0] core_live = core_flags & core_enables;
  wire logic [PERIPH_COUNT-1:0] periph_live = periph_flag & periph_enable;
  wire logic global_high = irq_control_main[CTL_GLOBAL_HIGH];
  wire logic periph_low = irq_control_main[CTL_PERIPH_LOW];
  wire logic high_running = (service == TLP_HIGH_SERVICE) || (service == TLP_HIGH_OVER_LOW);
  wire logic pulse_busy = core_req.vector_take;

  // priority mode requests
  wire logic high_pending = |(core_live & core_prio) | |(periph_live & periph_priority);
  wire logic low_pending = |(core_live & ~core_prio) | |(periph_live & ~periph_priority);
  wire logic prio_high_req = priority_levels_enable & global_high & high_pending;
  wire logic prio_low_req = priority_levels_enable & global_high & periph_low
                            & low_pending & ~high_running;
  // compatibility mode request, priority bits ignored
  wire logic compat_req = ~priority_levels_enable & global_high
                          & (|core_live | (periph_low & |periph_live));
  wire logic take_high = ~pulse_busy & (prio_high_req | compat_req);
  wire logic take_low = ~pulse_busy & prio_low_req & ~prio_high_req;
  wire logic take_any = take_high | take_low;
  wire logic [VECTOR_WIDTH-1:0] next_vector = take_low ? VECTOR_LOW : VECTOR_HIGH;

  // ***********************************
  // return handling
  // ***********************************
  wire logic ret_high = return_from_irq_instr & high_running;
  wire logic ret_low = return_from_irq_instr & (service == TLP_LOW_SERVICE);
  wire logic ret_compat = return_from_irq_instr & ~priority_levels_enable
                          & (service != TLP_IDLE);

  // ***********************************
  // control register next value
  // ***********************************
  logic [7:0] next_ctl;
  always_comb begin
    next_ctl = merge_byte(irq_control_main, wbyte, wr_ctl);
    // flags: hardware set wins over software clear
    next_ctl[CTL_TIMER0_FLAG] = next_ctl[CTL_TIMER0_FLAG] | events.timer0_overflow;
    next_ctl[CTL_EXT0_FLAG] = next_ctl[CTL_EXT0_FLAG] | ext0_event;
    next_ctl[CTL_PORT_FLAG] = next_ctl[CTL_PORT_FLAG] | port_event;
    if (ret_compat || ret_high) begin
      next_ctl[CTL_GLOBAL_HIGH] = 1'b1;
    end
    if (ret_low && priority_levels_enable) begin
      next_ctl[CTL_PERIPH_LOW] = 1'b1;
    end
    if (take_high) begin
      next_ctl[CTL_GLOBAL_HIGH] = 1'b0;
    end
    if (take_low) begin
      next_ctl[CTL_PERIPH_LOW] = 1'b0;
    end
  end

  // ***********************************
  // service state
  // ***********************************
  tlp_service_type next_service;
  always_comb begin
    next_service = service;
    case (service)
      TLP_IDLE: begin
        if (take_high) begin
          next_service = TLP_HIGH_SERVICE;
        end else if (take_low) begin
          next_service = TLP_LOW_SERVICE;
        end
      end
      TLP_LOW_SERVICE: begin
        if (take_high) begin
          next_service = TLP_HIGH_OVER_LOW;
        end else if (return_from_irq_instr) begin
          next_service = TLP_IDLE;
        end
      end
      TLP_HIGH_SERVICE: begin
        if (return_from_irq_instr) begin
          next_service = TLP_IDLE;
        end
      end
      TLP_HIGH_OVER_LOW: begin
        if (return_from_irq_instr) begin
          next_service = TLP_LOW_SERVICE;
        end
      end
      default: begin
        next_service = TLP_IDLE;
      end
    endcase
  end

  assign service_level = status_bits;

  // ***********************************
  // registers
  // ***********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_control_main <= RESET_IRQ_CONTROL_MAIN;
      priority_levels_enable <= 1'b0;
    end else if (clk_en) begin
      irq_control_main <= next_ctl;
      if (wr_rst) begin
        priority_levels_enable <= wbyte[RST_PRIO_LEVELS];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_flag <= RESET_BYTE_ZERO;
      periph_enable <= RESET_BYTE_ZERO;
      periph_priority <= RESET_BYTE_ZERO;
      core_priority <= RESET_CORE_PRIORITY;
    end else if (clk_en) begin
      periph_flag <= merge_byte(periph_flag, wbyte, wr_pflag) | events.periph_event;
      periph_enable <= merge_byte(periph_enable, wbyte, wr_pen);
      periph_priority <= merge_byte(periph_priority, wbyte, wr_ppri);
      core_priority <= merge_byte(core_priority, wbyte & RESET_CORE_PRIORITY, wr_cpri);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      service <= TLP_IDLE;
      core_req <= '0;
    end else if (clk_en) begin
      service <= next_service;
      core_req.vector_take <= take_any;
      core_req.vector_addr <= take_any ? next_vector : core_req.vector_addr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext0_sync <= 2'b00;
      port_sync <= '0;
      ext0_last <= 1'b0;
      port_last <= '0;
    end else if (clk_en) begin
      ext0_sync <= {ext0_sync[0], ext0_pin_in};
      port_sync <= {port_sync[PORT_WIDTH-1:0], port_change_pins};
      ext0_last <= ext0_now;
      port_last <= port_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && setup_phase && !pwrite) begin
      prdata <= {24'h00_0000, read_byte};
    end
  end

endmodule // tlp_irq_unit

/* src/tlp_pkg.sv */
// Purpose: shared constants and types for the two-level priority interrupt unit
// Assumes: 32-bit APB, one word per register
// Notes: all offsets are byte addresses
package tlp_pkg;

  // ***********************************
  // register map
  // ***********************************
  localparam logic [7:0] ADDR_IRQ_CONTROL_MAIN = 8'h00;
  localparam logic [7:0] ADDR_RESET_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_PERIPH_FLAG = 8'h08;
  localparam logic [7:0] ADDR_PERIPH_ENABLE = 8'h0C;
  localparam logic [7:0] ADDR_PERIPH_PRIORITY = 8'h10;
  localparam logic [7:0] ADDR_CORE_PRIORITY = 8'h14;
  localparam logic [7:0] ADDR_SERVICE_STATUS = 8'h18;

  // ***********************************
  // field positions
  // ***********************************
  localparam int CTL_GLOBAL_HIGH = 7;
  localparam int CTL_PERIPH_LOW = 6;
  localparam int CTL_TIMER0_EN = 5;
  localparam int CTL_EXT0_EN = 4;
  localparam int CTL_PORT_EN = 3;
  localparam int CTL_TIMER0_FLAG = 2;
  localparam int CTL_EXT0_FLAG = 1;
  localparam int CTL_PORT_FLAG = 0;
  localparam int RST_PRIO_LEVELS = 7;
  localparam int CPRI_EXT0_EDGE = 4;
  localparam int STAT_HIGH_ACTIVE = 0;
  localparam int STAT_LOW_ACTIVE = 1;

  // ***********************************
  // reset values and sizes
  // ***********************************
  localparam logic [7:0] RESET_IRQ_CONTROL_MAIN = 8'h00;
  localparam logic [7:0] RESET_BYTE_ZERO = 8'h00;
  localparam logic [7:0] RESET_CORE_PRIORITY = 8'h17;
  localparam int PERIPH_COUNT = 8;
  localparam int PORT_WIDTH = 4;
  localparam int VECTOR_WIDTH = 16;
  localparam logic [15:0] VECTOR_HIGH = 16'h0008;
  localparam logic [15:0] VECTOR_LOW = 16'h0018;

  // ***********************************
  // carriers
  // ***********************************
  typedef enum logic [1:0] {
    TLP_IDLE,
    TLP_LOW_SERVICE,
    TLP_HIGH_SERVICE,
    TLP_HIGH_OVER_LOW
  } tlp_service_type;

  typedef struct packed {
    logic timer0_overflow;
    logic [PERIPH_COUNT-1:0] periph_event;
  } tlp_event_type;

  typedef struct packed {
    logic vector_take;
    logic [VECTOR_WIDTH-1:0] vector_addr;
  } tlp_core_type;

endpackage

/* bench/tlp_irq_unit_asserts.sv */
// Purpose: port-level checks of the interrupt unit
// Assumes: single clock pclk, async active-low reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/10ps
module tlp_irq_unit_asserts
  import tlp_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // core side
  input wire logic return_from_irq_instr,
  input wire tlp_core_type core_req,
  input wire logic [1:0] service_level
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic tk = core_req.vector_take;
  wire logic hv = core_req.vector_addr == VECTOR_HIGH;
  wire logic rt = return_from_irq_instr && clk_en && !tk;
  property p_pulse; tk && clk_en |=> !tk; endproperty
  property p_vec; tk |-> hv || core_req.vector_addr == VECTOR_LOW; endproperty
  property p_hi; tk && hv |-> service_level[0]; endproperty
  property p_lo; tk && !hv |-> service_level == 2'b10; endproperty
  property p_nolo; service_level[0] && !tk && clk_en |=> !(tk && !hv); endproperty
  property p_entry; $rose(service_level[0]) |-> tk; endproperty
  property p_rethi; service_level == 2'b01 && rt |=> !service_level[0]; endproperty
  property p_retlo; service_level == 2'b10 && rt |=> !service_level[1] || tk; endproperty
  property p_hold; clk_en && !tk ##1 !tk |-> $stable(core_req.vector_addr); endproperty
  a_pulse: assert property (p_pulse) else $error("take longer than a cycle");
  a_vec: assert property (p_vec) else $error("bad vector");
  a_hi: assert property (p_hi) else $error("high take without high state");
  a_lo: assert property (p_lo) else $error("low take wrong state");
  a_nolo: assert property (p_nolo) else $error("low taken in high");
  a_entry: assert property (p_entry) else $error("service without take");
  a_rethi: assert property (p_rethi) else $error("high return ignored");
  a_retlo: assert property (p_retlo) else $error("low return ignored");
  a_hold: assert property (p_hold) else $error("vector moved");
  c_hi: cover property (tk && hv);
  c_lo: cover property (tk && !hv);
  c_pre: cover property (service_level == 2'b11);
endmodule // tlp_irq_unit_asserts
bind tlp_irq_unit tlp_irq_unit_asserts i_tlp_irq_unit_asserts (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .return_from_irq_instr(return_from_irq_instr), .core_req(core_req),
  .service_level(service_level));

/* bench/tlp_core_model.sv */
// Purpose: core-side partner: counts takes, issues returns
// Assumes: return only on bench command while a routine runs
// Notes: depth mirrors the return address stack
`timescale 1ns/10ps
module tlp_core_model
  import tlp_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // unit side
  input wire tlp_core_type core_req,
  output logic return_from_irq_instr,
  // bench side
  input wire logic ret_cmd,
  output logic [3:0] depth,
  output logic [7:0] take_cnt,
  output logic [15:0] last_vec
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      return_from_irq_instr <= 1'b0;
      depth <= 4'h0;
      take_cnt <= 8'h00;
      last_vec <= 16'h0000;
    end else begin
      return_from_irq_instr <= ret_cmd && depth != 4'h0;
      if (core_req.vector_take) begin
        depth <= depth + 4'h1;
        take_cnt <= take_cnt + 8'h01;
        last_vec <= core_req.vector_addr;
      end else if (return_from_irq_instr) begin
        depth <= depth - 4'h1;
      end
    end
  end
endmodule // tlp_core_model

/* bench/two_level_priority_irq_unit_tb_top.sv */
// Purpose: register and vectoring scenarios for the interrupt unit
// Assumes: zero-wait APB slave, clk_en held high
// Notes: software clears the serviced flag before each return; other flags may stay pending
`timescale 1ns/10ps
module two_level_priority_irq_unit_tb_top;
  import tlp_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, ext_pin0, ret, ret_cmd;
  logic [7:0] paddr, take_cnt, q;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, port_change_pins, depth;
  logic [15:0] last_vec;
  logic [1:0] service_level;
  tlp_event_type events;
  tlp_core_type core_req;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  tlp_irq_unit i_tlp_irq_unit (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_pin0(ext_pin0),
    .port_change_pins(port_change_pins), .events(events), .return_from_irq_instr(ret),
    .core_req(core_req), .service_level(service_level));
  tlp_core_model i_tlp_core_model (.pclk(pclk), .presetn(presetn), .core_req(core_req),
    .return_from_irq_instr(ret), .ret_cmd(ret_cmd), .depth(depth), .take_cnt(take_cnt),
    .last_vec(last_vec));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %0t vector %h exp %h", $time, g, e);
    end
  endtask
  // ***********************************
  // bus and core helpers
  // ***********************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    logic e;
    apb(1'b0, a, 8'h00, e);
    chk8(q, x);
  endtask
  task automatic ev(input logic [8:0] v);
    @(posedge pclk);
    events <= v;
    @(posedge pclk);
    events <= 9'h000;
  endtask
  task automatic rt;
    @(posedge pclk);
    ret_cmd <= 1'b1;
    @(posedge pclk);
    ret_cmd <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic tk(input logic [7:0] n, input logic [15:0] v);
    int k;
    k = 0;
    while (take_cnt !== n && k < 50) begin
      @(posedge pclk);
      k++;
    end
    chk8(take_cnt, n);
    chk16(last_vec, v);
  endtask
  task automatic nt(input logic [7:0] n);
    repeat (10) @(posedge pclk);
    chk8(take_cnt, n);
  endtask
  task automatic lat(input logic pin);
    int n;
    n = 0;
    @(posedge pclk);
    if (pin) ext_pin0 <= 1'b1;
    else port_change_pins <= 4'h5;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (core_req.vector_take !== 1'b1 && n < 10);
    chk8({7'h00, n >= 3 && n <= 4}, 8'h01);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test;
    end
  end
  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    logic e;
    {presetn, psel, penable, pwrite, ext_pin0, ret_cmd} = 6'h00;
    {paddr, pwdata, events, port_change_pins} = '0;
    clk_en = 1'b1;
    pstrb = 4'h1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_IRQ_CONTROL_MAIN, 8'h00);
    rd(ADDR_RESET_CONTROL, 8'h00);
    rd(ADDR_CORE_PRIORITY, 8'h17);
    apb(1'b0, 8'h1C, 8'h00, e);
    chk8({7'h00, e}, 8'h01);
    ev(9'h100);
    rd(ADDR_IRQ_CONTROL_MAIN, 8'h04);
    wr(ADDR_IRQ_CONTROL_MAIN, 8'hA4);
    tk(8'h01, VECTOR_HIGH);
    rd(ADDR_IRQ_CONTROL_MAIN, 8'h24);
    wr(ADDR_IRQ_CONTROL_MAIN, 8'h20);
    rt();
    rd(ADDR_IRQ_CONTROL_MAIN, 8'hA0);
    wr(ADDR_PERIPH_ENABLE, 8'h01);
    ev(9'h001);
    nt(8'h01);
    wr(ADDR_IRQ_CONTROL_MAIN, 8'hE0);
    tk(8'h02, VECTOR_HIGH);
    rd(ADDR_IRQ_CONTROL_MAIN, 8'h60);
    wr(ADDR_PERIPH_FLAG, 8'h00);
    rt();
    wr(ADDR_RESET_CONTROL, 8'h80);
    ev(9'h001);
    tk(8'h03, VECTOR_LOW);
    rd(ADDR_IRQ_CONTROL_MAIN, 8'hA0);
    ev(9'h100);
    tk(8'h04, VECTOR_HIGH);
    rd(ADDR_IRQ_CONTROL_MAIN, 8'h24);
    wr(ADDR_IRQ_CONTROL_MAIN, 8'h20);
    rt();
    rd(ADDR_IRQ_CONTROL_MAIN, 8'hA0);
    wr(ADDR_PERIPH_FLAG, 8'h00);
    rt();
    rd(ADDR_IRQ_CONTROL_MAIN, 8'hE0);
    ev(9'h100);
    tk(8'h05, VECTOR_HIGH);
    ev(9'h001);
    nt(8'h05);
    wr(ADDR_IRQ_CONTROL_MAIN, 8'h60);
    rt();
    tk(8'h06, VECTOR_LOW);
    wr(ADDR_PERIPH_FLAG, 8'h00);
    rt();
    wr(ADDR_PERIPH_PRIORITY, 8'h02);
    wr(ADDR_PERIPH_ENABLE, 8'h03);
    ev(9'h003);
    tk(8'h07, VECTOR_HIGH);
    nt(8'h07);
    wr(ADDR_PERIPH_FLAG, 8'h01);
    rt();
    tk(8'h08, VECTOR_LOW);
    wr(ADDR_PERIPH_FLAG, 8'h00);
    wr(ADDR_PERIPH_ENABLE, 8'h00);
    rt();
    wr(ADDR_IRQ_CONTROL_MAIN, 8'hF0);
    lat(1'b1);
    wr(ADDR_IRQ_CONTROL_MAIN, 8'h68);
    rt();
    lat(1'b0);
    finish_test();
  end
endmodule // two_level_priority_irq_unit_tb_top
